/* File: ascp_host.sv */
module ascp_host (
	input  wire logic clk,
	input  wire logic serial_out_primary,
	input  wire logic serial_out_secondary,
	output logic      serial_clock,
	output logic      frame_select_n,
	output logic      serial_cmd_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] rd_a;
	logic [15:0] rd_b;
	event       rd_done;
	initial begin
		serial_clock = 1'b1;
		frame_select_n = 1'b1;
		serial_cmd_in = 1'b0;
	end
	// Serial clock stands high between frames; bits go MSB first
	task automatic xfer(input logic [31:0] w, input int n, input bit cap);
		@(negedge clk);
		rd_a = 32'h0000_0000;
		rd_b = 16'h0000;
		frame_select_n = 1'b0;
		#24;
		for (int k = 0; k < n; k++) begin
			if (k < 32) rd_a[31 - k] = serial_out_primary;
			if (k < 16) rd_b[15 - k] = serial_out_secondary;
			serial_clock = 1'b0;
			serial_cmd_in = w[n - 1 - k];
			#24;
			serial_clock = 1'b1;
			#24;
		end
		frame_select_n = 1'b1;
		// Released line must not keep its last value
		serial_cmd_in = ~serial_cmd_in;
		if (cap) -> rd_done;
		#100;
	endtask
endmodule

/* File: ascp_pkg.sv */
package ascp_pkg;
	localparam int          FRAME_BITS       = 20;
	localparam logic [7:0]  ADDR_SLEEP_CTRL  = 8'h04;
	localparam logic [7:0]  ADDR_UNLOCK_KEY  = 8'h05;
	localparam logic [7:0]  ADDR_LANE_SEL    = 8'h0D;
	localparam logic [7:0]  ADDR_FORMAT_SEL  = 8'h11;
	localparam logic [7:0]  ADDR_REF_SRC     = 8'h20;
	localparam logic [7:0]  ADDR_REF_A_LOW   = 8'h24;
	localparam logic [7:0]  ADDR_REF_A_HIGH  = 8'h25;
	localparam logic [7:0]  ADDR_REF_B_LOW   = 8'h26;
	localparam logic [7:0]  ADDR_REF_B_HIGH  = 8'h27;
	localparam logic [7:0]  ADDR_INPUT_SETUP = 8'h28;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [3:0]  UNLOCK_PATTERN   = 4'h9;
	localparam int          LIGHT_SLEEP_POS  = 2;
	localparam int          DEEP_SLEEP_POS   = 1;
	localparam logic [7:0]  SLEEP_CTRL_MASK  = 8'h06;
	localparam logic [7:0]  UNLOCK_KEY_MASK  = 8'h0F;
	localparam logic [7:0]  LOW_BIT_MASK     = 8'h01;
	localparam logic [7:0]  FULL_MASK        = 8'hFF;
	localparam int          READ_OUT_BITS    = 8;

	typedef enum logic [3:0] {
		ASCP_OP_IDLE  = 4'b0000,
		ASCP_OP_WRITE = 4'b0001,
		ASCP_OP_READ  = 4'b0010,
		ASCP_OP_SET   = 4'b0011,
		ASCP_OP_CLEAR = 4'b0100
	} ascp_op_type;
endpackage

/* File: ascp_top.sv */
// Behaviour
// - Light sleep powers down both converter cores and oscillator; rest stays up.
// - Light sleep keeps enabled reference on and keeps ref level registers.
// - Deep sleep powers down all but serial interface and I/O.
// - All-zero frame is idle; no change; next frame shows conversion results.
// - Opcode 0001 writes data byte to addressed register.
// - Opcode 0010 selects addressed register for readback; data field ignored.
// - Opcode 0011 sets addressed register bits where data bits are one.
// - Opcode 0100 clears addressed register bits where data bits are one.
// - Undefined opcodes behave as idle with no register change.
// - Command bits are captured on host serial clock edges.
// - Frames are 20 bits right-aligned; shorter frames are discarded.
// - Longer frames decode only the final 20 bits received.
// - Read decoded at select rise; value presented during next frame.
// - First eight bits out in next frame are the requested register.
// - Write, set and clear decode at select rise and update register.
// - Sleep control writes accepted only after key low nibble holds 1001.
// - Sleep control bit 2 light, bit 1 deep; other bits read-only zero.
module ascp_top (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic serial_clock,
	input  wire logic frame_select_n,
	input  wire logic serial_cmd_in,
	input  wire logic [15:0] result_a,
	input  wire logic [15:0] result_b,
	output logic      serial_out_primary,
	output logic      serial_out_primary_oe_n,
	output logic      serial_out_secondary,
	output logic      serial_out_secondary_oe_n,
	output logic      core_a_power_down,
	output logic      core_b_power_down,
	output logic      oscillator_power_down,
	output logic      reference_power_down,
	output logic      single_lane_mode,
	output logic      twos_complement_mode,
	output logic      internal_reference_select,
	output logic      pseudo_diff_mode,
	output logic [8:0] ref_level_a,
	output logic [8:0] ref_level_b
);
	// Pin synchronisers: first stage is read only by the second
	logic [1:0] sclk_sync_q;
	logic [1:0] cs_sync_q;
	logic [1:0] sdi_sync_q;
	logic       sclk_prev_q;
	logic       cs_prev_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Serial clock idles high, so the detector starts high to avoid a false edge
			sclk_sync_q <= 2'h3;
			cs_sync_q   <= 2'h3;
			sdi_sync_q  <= 2'h0;
			sclk_prev_q <= 1'b1;
			cs_prev_q   <= 1'b1;
		end else begin
			sclk_sync_q <= {sclk_sync_q[0], serial_clock};
			cs_sync_q   <= {cs_sync_q[0], frame_select_n};
			sdi_sync_q  <= {sdi_sync_q[0], serial_cmd_in};
			sclk_prev_q <= sclk_sync_q[1];
			cs_prev_q   <= cs_sync_q[1];
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	logic cs_active;
	assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
	assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
	assign cs_rise   = cs_sync_q[1] & ~cs_prev_q;
	assign cs_fall   = ~cs_sync_q[1] & cs_prev_q;
	assign cs_active = ~cs_sync_q[1];

	// Shift register keeps only the last 20 bits; counter saturates at 20
	logic [ascp_pkg::FRAME_BITS-1:0] shift_q;
	logic [4:0]                      bit_count_q;
	localparam logic [4:0] FULL_COUNT = 5'(ascp_pkg::FRAME_BITS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q     <= '0;
			bit_count_q <= 5'h00;
		end else if (cs_fall) begin
			bit_count_q <= 5'h00;
		end else if (cs_active && sclk_rise) begin
			shift_q <= {shift_q[ascp_pkg::FRAME_BITS-2:0], sdi_sync_q[1]};
			if (bit_count_q != FULL_COUNT) begin
				bit_count_q <= bit_count_q + 5'h01;
			end
		end
	end

	logic        frame_ok;
	logic [3:0]  cmd_op;
	logic [7:0]  cmd_addr;
	logic [7:0]  cmd_data;
	assign frame_ok = cs_rise && (bit_count_q == FULL_COUNT);
	assign cmd_op   = shift_q[19:16];
	assign cmd_addr = shift_q[15:8];
	assign cmd_data = shift_q[7:0];

	// Register bank
	logic [7:0] sleep_control_q;
	logic [7:0] sleep_unlock_key_q;
	logic [7:0] output_lane_select_q;
	logic [7:0] result_format_select_q;
	logic [7:0] reference_source_select_q;
	logic [7:0] ref_level_a_low_q;
	logic [7:0] ref_level_a_high_q;
	logic [7:0] ref_level_b_low_q;
	logic [7:0] ref_level_b_high_q;
	logic [7:0] analog_input_setup_q;

	logic [7:0] cur_val;
	logic [7:0] wmask;
	always_comb begin
		cur_val = 8'h00;
		wmask   = 8'h00;
		case (cmd_addr)
			ascp_pkg::ADDR_SLEEP_CTRL: begin
				cur_val = sleep_control_q;
				wmask   = ascp_pkg::SLEEP_CTRL_MASK;
			end
			ascp_pkg::ADDR_UNLOCK_KEY: begin
				cur_val = sleep_unlock_key_q;
				wmask   = ascp_pkg::UNLOCK_KEY_MASK;
			end
			ascp_pkg::ADDR_LANE_SEL: begin
				cur_val = output_lane_select_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			ascp_pkg::ADDR_FORMAT_SEL: begin
				cur_val = result_format_select_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			ascp_pkg::ADDR_REF_SRC: begin
				cur_val = reference_source_select_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			ascp_pkg::ADDR_REF_A_LOW: begin
				cur_val = ref_level_a_low_q;
				wmask   = ascp_pkg::FULL_MASK;
			end
			ascp_pkg::ADDR_REF_A_HIGH: begin
				cur_val = ref_level_a_high_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			ascp_pkg::ADDR_REF_B_LOW: begin
				cur_val = ref_level_b_low_q;
				wmask   = ascp_pkg::FULL_MASK;
			end
			ascp_pkg::ADDR_REF_B_HIGH: begin
				cur_val = ref_level_b_high_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			ascp_pkg::ADDR_INPUT_SETUP: begin
				cur_val = analog_input_setup_q;
				wmask   = ascp_pkg::LOW_BIT_MASK;
			end
			default: begin
				cur_val = 8'h00;
				wmask   = 8'h00;
			end
		endcase
	end

	logic [7:0] new_val;
	logic       do_update;
	always_comb begin
		new_val   = cur_val;
		do_update = 1'b0;
		case (cmd_op)
			ascp_pkg::ASCP_OP_WRITE: begin
				new_val   = (cur_val & ~wmask) | (cmd_data & wmask);
				do_update = frame_ok;
			end
			ascp_pkg::ASCP_OP_SET: begin
				new_val   = cur_val | (cmd_data & wmask);
				do_update = frame_ok;
			end
			ascp_pkg::ASCP_OP_CLEAR: begin
				new_val   = cur_val & ~(cmd_data & wmask);
				do_update = frame_ok;
			end
			default: begin
				new_val   = cur_val;
				do_update = 1'b0;
			end
		endcase
	end

	logic key_ok;
	assign key_ok = (sleep_unlock_key_q[3:0] == ascp_pkg::UNLOCK_PATTERN);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_control_q           <= ascp_pkg::REG_RESET;
			sleep_unlock_key_q        <= ascp_pkg::REG_RESET;
			output_lane_select_q      <= ascp_pkg::REG_RESET;
			result_format_select_q    <= ascp_pkg::REG_RESET;
			reference_source_select_q <= ascp_pkg::REG_RESET;
			ref_level_a_low_q         <= ascp_pkg::REG_RESET;
			ref_level_a_high_q        <= ascp_pkg::REG_RESET;
			ref_level_b_low_q         <= ascp_pkg::REG_RESET;
			ref_level_b_high_q        <= ascp_pkg::REG_RESET;
			analog_input_setup_q      <= ascp_pkg::REG_RESET;
		end else if (do_update) begin
			case (cmd_addr)
				ascp_pkg::ADDR_SLEEP_CTRL: begin
					if (key_ok) begin
						sleep_control_q <= new_val;
					end
				end
				ascp_pkg::ADDR_UNLOCK_KEY:  sleep_unlock_key_q        <= new_val;
				ascp_pkg::ADDR_LANE_SEL:    output_lane_select_q      <= new_val;
				ascp_pkg::ADDR_FORMAT_SEL:  result_format_select_q    <= new_val;
				ascp_pkg::ADDR_REF_SRC:     reference_source_select_q <= new_val;
				ascp_pkg::ADDR_REF_A_LOW:   ref_level_a_low_q         <= new_val;
				ascp_pkg::ADDR_REF_A_HIGH:  ref_level_a_high_q        <= new_val;
				ascp_pkg::ADDR_REF_B_LOW:   ref_level_b_low_q         <= new_val;
				ascp_pkg::ADDR_REF_B_HIGH:  ref_level_b_high_q        <= new_val;
				ascp_pkg::ADDR_INPUT_SETUP: analog_input_setup_q      <= new_val;
				default: begin
				end
			endcase
		end
	end

	// Readback: read frame arms a byte for the next frame
	logic        read_pending_q;
	logic [7:0]  read_byte_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			read_pending_q <= 1'b0;
			read_byte_q    <= 8'h00;
		end else if (cs_rise) begin
			read_pending_q <= frame_ok && (cmd_op == ascp_pkg::ASCP_OP_READ);
			read_byte_q    <= cur_val;
		end
	end

	// Output shifters; register read goes first on the primary lane
	logic [31:0] out_a_q;
	logic [15:0] out_b_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_a_q                   <= 32'h0000_0000;
			out_b_q                   <= 16'h0000;
			serial_out_primary        <= 1'b0;
			serial_out_secondary      <= 1'b0;
			serial_out_primary_oe_n   <= 1'b1;
			serial_out_secondary_oe_n <= 1'b1;
		end else if (cs_fall) begin
			serial_out_primary_oe_n   <= 1'b0;
			serial_out_secondary_oe_n <= 1'b0;
			if (read_pending_q) begin
				serial_out_primary <= read_byte_q[7];
				out_a_q            <= {read_byte_q[6:0], 25'h0000000};
				serial_out_secondary <= 1'b0;
				out_b_q            <= 16'h0000;
			end else if (output_lane_select_q[0]) begin
				serial_out_primary   <= result_a[15];
				out_a_q              <= {result_a[14:0], result_b, 1'b0};
				serial_out_secondary <= 1'b0;
				out_b_q              <= 16'h0000;
			end else begin
				serial_out_primary   <= result_a[15];
				out_a_q              <= {result_a[14:0], 17'h00000};
				serial_out_secondary <= result_b[15];
				out_b_q              <= {result_b[14:0], 1'b0};
			end
		end else if (cs_rise) begin
			serial_out_primary_oe_n   <= 1'b1;
			serial_out_secondary_oe_n <= 1'b1;
		end else if (cs_active && sclk_fall) begin
			serial_out_primary   <= out_a_q[31];
			out_a_q              <= {out_a_q[30:0], 1'b0};
			serial_out_secondary <= out_b_q[15];
			out_b_q              <= {out_b_q[14:0], 1'b0};
		end
	end

	// Power control from sleep control; mode and reference level outputs from their registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			core_a_power_down         <= 1'b0;
			core_b_power_down         <= 1'b0;
			oscillator_power_down     <= 1'b0;
			reference_power_down      <= 1'b0;
			single_lane_mode          <= 1'b0;
			twos_complement_mode      <= 1'b0;
			internal_reference_select <= 1'b0;
			pseudo_diff_mode          <= 1'b0;
			ref_level_a               <= 9'h000;
			ref_level_b               <= 9'h000;
		end else begin
			core_a_power_down     <= sleep_control_q[ascp_pkg::LIGHT_SLEEP_POS]
				| sleep_control_q[ascp_pkg::DEEP_SLEEP_POS];
			core_b_power_down     <= sleep_control_q[ascp_pkg::LIGHT_SLEEP_POS]
				| sleep_control_q[ascp_pkg::DEEP_SLEEP_POS];
			oscillator_power_down <= sleep_control_q[ascp_pkg::LIGHT_SLEEP_POS]
				| sleep_control_q[ascp_pkg::DEEP_SLEEP_POS];
			// Light sleep leaves the reference alone so wake-up is quick
			reference_power_down  <= sleep_control_q[ascp_pkg::DEEP_SLEEP_POS];
			single_lane_mode          <= output_lane_select_q[0];
			twos_complement_mode      <= result_format_select_q[0];
			internal_reference_select <= reference_source_select_q[0];
			pseudo_diff_mode          <= analog_input_setup_q[0];
			ref_level_a <= {ref_level_a_high_q[0], ref_level_a_low_q};
			ref_level_b <= {ref_level_b_high_q[0], ref_level_b_low_q};
		end
	end
endmodule

/* File: ascp_top_assertions.sv */
module ascp_top_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       frame_select_n,
	input wire logic       serial_out_primary_oe_n,
	input wire logic       serial_out_secondary_oe_n,
	input wire logic       core_a_power_down,
	input wire logic       core_b_power_down,
	input wire logic       oscillator_power_down,
	input wire logic       reference_power_down,
	input wire logic [8:0] ref_level_a,
	input wire logic [8:0] ref_level_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_OE_IDLE: assert property (frame_select_n [*8] |-> serial_out_primary_oe_n)
		else $error("primary lane driven outside a frame");
	AST_OE_FRAME: assert property (!frame_select_n [*8] |-> !serial_out_primary_oe_n)
		else $error("primary lane released inside a frame");
	AST_SEC_IDLE: assert property (frame_select_n [*8] |-> serial_out_secondary_oe_n)
		else $error("secondary lane driven outside a frame");
	AST_SEL_RISE: assert property ($rose(frame_select_n) |-> ##[1:6] serial_out_primary_oe_n)
		else $error("primary lane not released after frame end");
	AST_SEL_FALL: assert property ($fell(frame_select_n) |-> ##[1:6] !serial_out_primary_oe_n)
		else $error("primary lane not driven after frame start");
	AST_SLEEP_TRIO: assert property (core_a_power_down == core_b_power_down
		&& core_a_power_down == oscillator_power_down)
		else $error("cores and oscillator power state differ");
	AST_DEEP_ALL: assert property (reference_power_down |-> core_a_power_down)
		else $error("deep sleep left a core powered");
	// Decode only follows a frame end, so outputs never move mid-frame
	AST_CFG_DECODE: assert property ($changed({ref_level_a, ref_level_b, core_a_power_down,
		reference_power_down}) |-> frame_select_n)
		else $error("configuration changed inside a frame");
	COV_DEEP: cover property ($rose(reference_power_down));
	COV_LIGHT: cover property (core_a_power_down && !reference_power_down);
	COV_FRAME: cover property ($fell(frame_select_n));
endmodule

bind ascp_top ascp_top_checker u_chk (.clk, .rst_n, .frame_select_n, .serial_out_primary_oe_n,
	.serial_out_secondary_oe_n, .core_a_power_down, .core_b_power_down, .oscillator_power_down,
	.reference_power_down, .ref_level_a, .ref_level_b);

/* File: test_ascp_top.sv */
module test_ascp_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       serial_clock, frame_select_n, serial_cmd_in;
	logic [15:0] result_a, result_b;
	logic       serial_out_primary, serial_out_primary_oe_n;
	logic       serial_out_secondary, serial_out_secondary_oe_n;
	logic       core_a_power_down, core_b_power_down, oscillator_power_down;
	logic       reference_power_down, single_lane_mode, twos_complement_mode;
	logic       internal_reference_select, pseudo_diff_mode;
	logic [8:0] ref_level_a, ref_level_b;
	logic [47:0] exp_q[$];
	logic [47:0] exp_e;
	logic [3:0] pwr;
	logic [3:0] modes;
	logic [7:0] wv[10];
	logic [7:0] addr_tbl[10] = '{8'h04, 8'h05, 8'h0D, 8'h11, 8'h20, 8'h24, 8'h25, 8'h26,
		8'h27, 8'h28};
	logic [7:0] mask_tbl[10] = '{8'h06, 8'h0F, 8'h01, 8'h01, 8'h01, 8'hFF, 8'h01, 8'hFF,
		8'h01, 8'h01};
	int         failures = 0;
	int         checks_done = 0;
	int         seed = 72993;

	always #2.5 clk = ~clk;

	assign pwr   = {core_a_power_down, core_b_power_down, oscillator_power_down,
		reference_power_down};
	assign modes = {single_lane_mode, twos_complement_mode, internal_reference_select,
		pseudo_diff_mode};

	ascp_top dut (.clk, .rst_n, .serial_clock, .frame_select_n, .serial_cmd_in, .result_a,
		.result_b, .serial_out_primary, .serial_out_primary_oe_n, .serial_out_secondary,
		.serial_out_secondary_oe_n, .core_a_power_down, .core_b_power_down,
		.oscillator_power_down, .reference_power_down, .single_lane_mode,
		.twos_complement_mode, .internal_reference_select, .pseudo_diff_mode, .ref_level_a,
		.ref_level_b);
	ascp_host host (.clk, .serial_out_primary, .serial_out_secondary, .serial_clock,
		.frame_select_n, .serial_cmd_in);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
		host.xfer({4'h0, op, a, d}, 20, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		// Read byte leads the primary lane, then zeros; secondary stays low
		exp_q.push_back({e, 40'h0});
		wr(4'h2, a, 8'h00);
		host.xfer(32'h0, 20, 1'b1);
	endtask
	task automatic res(input logic [47:0] e);
		exp_q.push_back(e);
		wr(4'h0, 8'h00, 8'h00);
		host.xfer(32'h0, 32, 1'b1);
	endtask

	always @(host.rd_done) begin
		exp_e = exp_q.pop_front();
		check(host.rd_a, exp_e[47:16]);
		check(host.rd_b, exp_e[15:0]);
	end

	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		result_a = 16'($random(seed));
		result_b = 16'($random(seed));
		repeat (20) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		repeat (4) @(negedge clk);
		foreach (addr_tbl[i]) rd(addr_tbl[i], 8'h00);
		// Sleep control comes first, while the key is still clear
		foreach (addr_tbl[i]) begin
			wv[i] = 8'($random(seed));
			wr(4'h1, addr_tbl[i], wv[i]);
			rd(addr_tbl[i], (i == 0) ? 8'h00 : wv[i] & mask_tbl[i]);
		end
		check(modes, {wv[2][0], wv[3][0], wv[4][0], wv[9][0]});
		check(ref_level_b, {wv[8][0], wv[7]});
		// Readback frame carries the next command
		exp_q.push_back({wv[7], 40'h0});
		wr(4'h2, 8'h26, 8'h00);
		host.xfer({12'h126, 8'h3C}, 20, 1'b1);
		rd(8'h26, 8'h3C);
		wr(4'h1, 8'h0D, 8'h00);
		res({result_a, 16'h0000, result_b});
		wr(4'h1, 8'h0D, 8'h01);
		res({result_a, result_b, 16'h0000});
		wr(4'h1, 8'h24, 8'hA5);
		wr(4'h3, 8'h24, 8'h0F);
		rd(8'h24, 8'hAF);
		wr(4'h4, 8'h24, 8'h81);
		// Data LSB low, so a short frame that slipped through would decode as a write
		for (int op = 5; op < 16; op++) wr(4'(op), 8'h24, 8'hFE);
		host.xfer({4'h0, 20'h12453}, 19, 1'b0);
		rd(8'h24, 8'h2E);
		host.xfer({4'hF, 20'h12477}, 24, 1'b0);
		wr(4'h0, 8'h30, 8'h5A);
		rd(8'h30, 8'h00);
		wr(4'h1, 8'h05, 8'h09);
		wr(4'h1, 8'h04, 8'hFF);
		check(pwr, 4'hF);
		rd(8'h04, 8'h06);
		wr(4'h1, 8'h04, 8'h04);
		check(pwr, 4'hE);
		check(ref_level_a, {wv[6][0], 8'h77});
		wr(4'h1, 8'h04, 8'h00);
		wr(4'h1, 8'h05, 8'h00);
		wr(4'h1, 8'h04, 8'h04);
		check({core_a_power_down, reference_power_down}, 9'h000);
		rd(8'h04, 8'h00);
		check(9'(exp_q.size()), 9'h000);
		report_and_stop();
	end
endmodule
